// ### verilog/senc_pkg.sv
package senc_pkg;
  // Register indices on the plain register port (word addresses)
  localparam logic [3:0] ADDR_CTRL_WORD = 4'h0;
  localparam logic [3:0] ADDR_RESULT_A = 4'h1;
  localparam logic [3:0] ADDR_RESULT_B = 4'h2;
  localparam logic [3:0] ADDR_SETUP = 4'h3;
  localparam logic [3:0] ADDR_INPUT_CTRL = 4'h4;

  // Channel control word field positions
  localparam int CMD_MSB = 31;
  localparam int CMD_LSB = 16;
  localparam int PAR_MSB = 15;
  localparam int PAR_LSB = 14;
  localparam int ONE_SHOT_BIT = 13;
  localparam int ARM_BIT = 12;
  localparam int GRAY_BIT = 11;
  localparam int READY_BIT = 10;
  localparam int STAT_MSB = 9;
  localparam int STAT_LSB = 6;
  localparam int POS_MSB = 5;
  localparam int POS_LSB = 0;

  // Shared setup word field positions
  localparam int MDIV_MSB = 31;
  localparam int MDIV_LSB = 24;
  localparam int NDIV_MSB = 23;
  localparam int NDIV_LSB = 20;
  localparam int TCLK_BIT = 17;
  localparam int TEDGE_BIT = 16;
  localparam int TDLY_MSB = 15;
  localparam int TDLY_LSB = 8;
  localparam int PROTO_MSB = 7;
  localparam int PROTO_LSB = 0;

  // Input control word: line buffer enable bit
  localparam int BUF_EN_BIT = 0;

  // Reset values
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] SETUP_RESET = 32'h0000_0000;

  // Parity codes
  localparam logic [1:0] PAR_NONE = 2'h0;
  localparam logic [1:0] PAR_ODD = 2'h1;
  localparam logic [1:0] PAR_EVEN = 2'h2;

  // Protocol codes
  localparam logic [7:0] PROTO_QUAD = 8'h00;
  localparam logic [7:0] PROTO_SPI = 8'h01;

  // Largest status count accepted
  localparam logic [3:0] STAT_MAX = 4'hC;

  // Internal clock rate and fractional timer width
  localparam int REF_CLK_MHZ = 100;
  localparam int FRAC_BITS = 8;

  // Transfer engine states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_DELAY = 3'b001,
    ST_SHIFT_LO = 3'b010,
    ST_SHIFT_HI = 3'b011,
    ST_DONE = 3'b100
  } xfer_state_t;

  // Serial line pins, each pair seen as one logic level
  typedef struct packed {
    logic clk_o;
    logic clk_oe;
    logic sel_o;
    logic sel_oe;
  } line_out_t;

  typedef struct packed {
    logic data_i;
    logic clk_i;
  } line_in_t;
endpackage

// ### verilog/quad_counter.sv
`timescale 1ns/1ps
module quad_counter
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Phase inputs and enable
  input wire logic en,
  input wire logic phase_a,
  input wire logic phase_b,
  input wire logic servo_tick,
  // Latched result, 24 whole plus 8 fraction bits
  output logic [31:0] result
);
  import senc_pkg::*;

  typedef struct packed {
    logic [1:0] ab;
    logic [23:0] count;
    logic [7:0] since;
    logic [7:0] period;
    logic [31:0] result;
  } qstate_t;

  qstate_t q_ff;
  qstate_t nxt_q;
  logic step;
  logic dir;
  logic [FRAC_BITS-1:0] frac;

  assign step = (q_ff.ab[0] ^ phase_a) ^ (q_ff.ab[1] ^ phase_b);
  // Forward when new A differs from old B
  assign dir = phase_a ^ q_ff.ab[1];
  assign result = q_ff.result;

  // Fraction estimate: time since last edge over last edge period
  always_comb
  begin
    if (q_ff.period == 8'h00 || q_ff.since >= q_ff.period)
      frac = 8'hFF;
    else
      frac = 8'(({8'h00, q_ff.since} << 8) / {8'h00, q_ff.period});
  end

  always_comb
  begin
    nxt_q = q_ff;
    nxt_q.ab = {phase_b, phase_a};
    if (q_ff.since != 8'hFF)
      nxt_q.since = q_ff.since + 8'h01;
    if (en && step && (q_ff.ab != {phase_b, phase_a}))
    begin
      nxt_q.count = dir ? q_ff.count + 24'h1 : q_ff.count - 24'h1;
      nxt_q.period = q_ff.since;
      nxt_q.since = 8'h00;
    end
    // Latch on each servo interrupt (see R16)
    if (servo_tick)
      nxt_q.result = {q_ff.count, frac};
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      q_ff <= '0;
    else
      q_ff <= nxt_q;
  end
endmodule

// ### verilog/senc_channel.sv
// The implementer's own choices: strobed register access and the placing of the registers.
`timescale 1ns/1ps
// Functional notes
// R1: Bits 31-16 are the transmitted command; the code stores them but never sends them
// R2: Parity 0 none, 1 odd, 2 even, 3 reserved
// R3: Bit 13 picks continuous or one-shot sampling
// R4: Bit 12 arms sampling; zero means none
// R5: One-shot sample clears arm; host rearms
// R6: Bit 11 converts Gray position to binary
// R7: Ready bit low in transfer, high after
// R8: Status bit count, zero to twelve, SPI
// R9: Position bit count sets bits clocked in
// R10: Control word accessed only whole
// R11: Buffer enable zero keeps lines undriven
// R12: Buffer enable one drives serial lines
// R13: Protocol zero makes a second quadrature decoder
// R14: Quadrature: A on data, B on clock
// R15: Quadrature ignores the control word
// R16: Quadrature count latched each servo interrupt
// R17: SPI uses data, select and clock pairs
// R18: Host sets divisor to rate minus one
// R19: Serial clock is ref over M+1, 2^N; with M=N=0 the code gives only ref over 2
// R20: Trigger from phase or servo clock edge
// R21: Start needs buffers, arm, trigger, delay
module senc_channel
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Motion clocks
  input wire logic phase_clk,
  input wire logic servo_clk,
  // Serial lines
  input wire senc_pkg::line_in_t line_in,
  output senc_pkg::line_out_t line_out,
  // Alternate pin functions when buffers are off
  input wire logic [3:0] hall_flags_pin,
  input wire logic index_pin,
  output logic [3:0] hall_flags,
  output logic index_in,
  output logic alt_pins_valid
);
  import senc_pkg::*;

  // Assertions below share this clock and reset
  default clocking main_cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);

  typedef struct packed {
    logic [31:0] ctrl;
    logic [31:0] setup;
    logic buf_en;
    logic [31:0] res_a;
    logic [31:0] res_b;
    logic [31:0] rdata;
    xfer_state_t st;
    logic [8:0] mcnt;
    logic [15:0] ncnt;
    logic [7:0] dly;
    logic [5:0] bits_left;
    logic [43:0] shreg; // Up to 32 position plus 12 status bits
    logic par_acc;
    logic phase_q;
    logic servo_q;
    logic sclk;
    logic sel;
  } cstate_t;

  cstate_t s_ff;
  cstate_t nxt_s;

  // Field views
  logic [1:0] par_sel;
  logic one_shot;
  logic armed;
  logic gray_en;
  logic [3:0] stat_cnt;
  logic [5:0] pos_cnt;
  logic [7:0] m_div;
  logic [3:0] n_div;
  logic [7:0] proto;
  logic quad_mode;
  logic phase_rise;
  logic phase_fall;
  logic servo_rise;
  logic servo_fall;
  logic trig;
  logic sclk_tick;
  logic sclk_end;
  logic [5:0] total_bits;
  logic [31:0] pos_raw;
  logic [31:0] pos_bin;
  logic [11:0] stat_raw;
  logic par_err;
  logic [31:0] quad_res;
  logic [31:0] ctrl_view;
  logic [15:0] n_limit;

  assign par_sel = s_ff.ctrl[PAR_MSB:PAR_LSB];
  assign one_shot = s_ff.ctrl[ONE_SHOT_BIT];
  assign armed = s_ff.ctrl[ARM_BIT];
  assign gray_en = s_ff.ctrl[GRAY_BIT];
  // Counts above twelve clamp to twelve (see R8)
  assign stat_cnt = (s_ff.ctrl[STAT_MSB:STAT_LSB] > STAT_MAX) ?
                    STAT_MAX : s_ff.ctrl[STAT_MSB:STAT_LSB];
  assign pos_cnt = s_ff.ctrl[POS_MSB:POS_LSB];
  assign m_div = s_ff.setup[MDIV_MSB:MDIV_LSB];
  assign n_div = s_ff.setup[NDIV_MSB:NDIV_LSB];
  assign proto = s_ff.setup[PROTO_MSB:PROTO_LSB];
  assign quad_mode = (proto == PROTO_QUAD);

  // Motion clock edges from the previous sample
  assign phase_rise = phase_clk & ~s_ff.phase_q;
  assign phase_fall = ~phase_clk & s_ff.phase_q;
  assign servo_rise = servo_clk & ~s_ff.servo_q;
  assign servo_fall = ~servo_clk & s_ff.servo_q;

  // Trigger source and edge from the shared setup word (see R20)
  always_comb
  begin
    unique case ({s_ff.setup[TCLK_BIT], s_ff.setup[TEDGE_BIT]})
      2'b00: trig = phase_rise;
      2'b01: trig = phase_fall;
      2'b10: trig = servo_rise;
      2'b11: trig = servo_fall;
    endcase
  end

  // Line period is (M+1)*2^N cycles, one tick at its end and one near its
  // middle; with N=0 an odd M+1 gives uneven halves, M=N=0 only half rate (see R19)
  assign n_limit = 16'((17'h1 << n_div) - 17'h1);
  assign sclk_end = (s_ff.mcnt[7:0] == m_div) && (s_ff.ncnt == n_limit);
  assign sclk_tick = sclk_end || ((n_div == 4'h0) ?
    (s_ff.mcnt[7:0] == (m_div >> 1)) :
    ((s_ff.mcnt[7:0] == m_div) && (s_ff.ncnt == (n_limit >> 1))));

  // Status bits come after the position bits on the line (see R8)
  assign total_bits = 6'(pos_cnt + 6'(stat_cnt));

  // Received word is right-aligned; split into position and status
  always_comb
  begin
    stat_raw = 12'(s_ff.shreg & ((44'h1 << stat_cnt) - 44'h1));
    pos_raw = 32'(s_ff.shreg >> stat_cnt) &
              ((pos_cnt == 6'h00) ? 32'h0 : ((32'h1 << pos_cnt) - 32'h1));
  end

  // Gray to binary over the programmed width (see R6)
  genvar gi;
  generate
    for (gi = 0; gi < 32; gi++)
    begin : g_gray
      assign pos_bin[gi] = gray_en ? ^(pos_raw >> gi) : pos_raw[gi];
    end
  endgenerate

  // Parity over received bits; odd expects odd ones count (see R2)
  always_comb
  begin
    unique case (par_sel)
      PAR_ODD: par_err = ~s_ff.par_acc;
      PAR_EVEN: par_err = s_ff.par_acc;
      default: par_err = 1'b0;
    endcase
  end

  // Supplemental quadrature decoder (see R13) (see R14)
  quad_counter u_quad
  (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .en(quad_mode && s_ff.buf_en),
    .phase_a(line_in.data_i),
    .phase_b(line_in.clk_i),
    .servo_tick(servo_fall),
    .result(quad_res)
  );

  // Read view of the control word with live ready bit (see R10)
  assign ctrl_view = s_ff.ctrl;

  // Main next-state logic
  always_comb
  begin
    nxt_s = s_ff;
    nxt_s.phase_q = phase_clk;
    nxt_s.servo_q = servo_clk;
    nxt_s.rdata = 32'h0;

    // Divider runs only in the delay and shift states (see R19)
    if (s_ff.st == ST_SHIFT_LO || s_ff.st == ST_SHIFT_HI ||
        s_ff.st == ST_DELAY)
    begin
      if (s_ff.mcnt[7:0] == m_div)
      begin
        nxt_s.mcnt = 9'h000;
        nxt_s.ncnt = (s_ff.ncnt == n_limit) ? 16'h0000 :
                     s_ff.ncnt + 16'h0001;
      end
      else
        nxt_s.mcnt = s_ff.mcnt + 9'h001;
    end
    else
    begin
      nxt_s.mcnt = 9'h000;
      nxt_s.ncnt = 16'h0000;
    end

    unique case (s_ff.st)
      ST_IDLE:
      begin
        nxt_s.sclk = 1'b1;
        nxt_s.sel = 1'b0;
        // Start only with buffers, arm and a trigger (see R21) (see R4)
        // Quadrature ignores the control word (see R15)
        if (s_ff.buf_en && armed && trig && !quad_mode)
        begin
          nxt_s.st = ST_DELAY;
          nxt_s.dly = s_ff.setup[TDLY_MSB:TDLY_LSB];
          // Ready low while the transfer runs (see R7)
          nxt_s.ctrl[READY_BIT] = 1'b0;
          // One-shot clears its own arm (see R3) (see R5)
          if (one_shot)
            nxt_s.ctrl[ARM_BIT] = 1'b0;
        end
      end
      ST_DELAY:
      begin
        // Delay counts whole line clock periods (see R21)
        if (sclk_end)
        begin
          if (s_ff.dly == 8'h00)
          begin
            nxt_s.st = ST_SHIFT_HI;
            nxt_s.sel = 1'b1;
            nxt_s.bits_left = total_bits;
            nxt_s.shreg = 44'h0;
            nxt_s.par_acc = 1'b0;
          end
          else
            nxt_s.dly = s_ff.dly - 8'h01;
        end
      end
      ST_SHIFT_HI:
      begin
        // Falling edge launches the encoder's next bit (see R17)
        if (sclk_tick)
        begin
          if (s_ff.bits_left == 6'h00)
            nxt_s.st = ST_DONE;
          else
          begin
            nxt_s.sclk = 1'b0;
            nxt_s.st = ST_SHIFT_LO;
          end
        end
      end
      ST_SHIFT_LO:
      begin
        // Rising edge samples the data pair (see R9)
        if (sclk_tick)
        begin
          nxt_s.sclk = 1'b1;
          nxt_s.shreg = {s_ff.shreg[42:0], line_in.data_i};
          nxt_s.par_acc = s_ff.par_acc ^ line_in.data_i;
          nxt_s.bits_left = s_ff.bits_left - 6'h01;
          nxt_s.st = ST_SHIFT_HI;
        end
      end
      ST_DONE:
      begin
        nxt_s.sel = 1'b0;
        nxt_s.res_a = pos_bin;
        nxt_s.res_b = {stat_raw, 19'h0, par_err};
        // Data ready once the value is stored (see R7)
        nxt_s.ctrl[READY_BIT] = 1'b1;
        nxt_s.st = ST_IDLE;
      end
      default:
        nxt_s.st = ST_IDLE;
    endcase

    // Quadrature mode reports the latched count (see R16)
    if (quad_mode)
      nxt_s.res_a = quad_res;

    // Register writes; whole word only, ready bit kept (see R10)
    if (reg_wr)
    begin
      unique case (reg_addr)
        ADDR_CTRL_WORD:
        begin
          // Ready bit keeps the engine's own next value (see R7)
          nxt_s.ctrl = {reg_wdata[31:READY_BIT+1], nxt_s.ctrl[READY_BIT],
                        reg_wdata[READY_BIT-1:0]};
          // A start in this cycle keeps its one-shot clear (see R5)
          if (s_ff.st == ST_IDLE && nxt_s.st == ST_DELAY && one_shot)
            nxt_s.ctrl[ARM_BIT] = 1'b0;
        end
        ADDR_SETUP: nxt_s.setup = reg_wdata;
        ADDR_INPUT_CTRL: nxt_s.buf_en = reg_wdata[BUF_EN_BIT];
        default: ;
      endcase
    end

    // Register reads, data in the next cycle
    if (reg_rd)
    begin
      unique case (reg_addr)
        ADDR_CTRL_WORD: nxt_s.rdata = ctrl_view;
        ADDR_RESULT_A: nxt_s.rdata = s_ff.res_a;
        ADDR_RESULT_B: nxt_s.rdata = s_ff.res_b;
        ADDR_SETUP: nxt_s.rdata = s_ff.setup;
        ADDR_INPUT_CTRL: nxt_s.rdata = {31'h0, s_ff.buf_en};
        default: nxt_s.rdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      s_ff <= '0;
      s_ff.ctrl <= CTRL_RESET;
      s_ff.setup <= SETUP_RESET;
      s_ff.sclk <= 1'b1;
    end
    else
      s_ff <= nxt_s;
  end

  assign reg_rdata = s_ff.rdata;

  // Drive lines only with buffers on and a serial protocol (see R11)
  // (see R12) (see R14)
  assign line_out.clk_o = s_ff.sclk;
  assign line_out.clk_oe = s_ff.buf_en && !quad_mode;
  assign line_out.sel_o = s_ff.sel;
  assign line_out.sel_oe = s_ff.buf_en && (proto == PROTO_SPI);
  // Alternate functions only while buffers are off (see R11)
  assign hall_flags = s_ff.buf_en ? 4'h0 : hall_flags_pin;
  assign index_in = s_ff.buf_en ? 1'b0 : index_pin;
  assign alt_pins_valid = ~s_ff.buf_en;

  // Command field reserved for command-based protocols (see R1)
  logic [15:0] cmd_word;
  assign cmd_word = s_ff.ctrl[CMD_MSB:CMD_LSB];

  // Assertions
  sequence s_start;
    s_ff.st == ST_IDLE && nxt_s.st == ST_DELAY && !reg_wr;
  endsequence
  AST_ONESHOT_CLEAR: assert property (s_start and one_shot |=> // see R5
    !s_ff.ctrl[ARM_BIT]) else $error("one-shot start left arm set");
  AST_CONT_KEEP: assert property (s_start and !one_shot |=> // see R3
    s_ff.ctrl[ARM_BIT]) else $error("continuous start cleared arm");
  AST_NO_START_UNARMED: assert property ( // see R4
    s_ff.st == ST_IDLE && !armed |=> s_ff.st == ST_IDLE)
    else $error("transfer started while unarmed");
  AST_READY_LOW: assert property (s_ff.st == ST_SHIFT_LO |-> // see R7
    !s_ff.ctrl[READY_BIT]) else $error("ready high during transfer");
  AST_READY_SET: assert property (s_ff.st == ST_DONE |=> // see R7
    s_ff.ctrl[READY_BIT]) else $error("ready not set after transfer");
  AST_BUF_OFF: assert property ( // see R11
    !s_ff.buf_en |-> !line_out.clk_oe && !line_out.sel_oe &&
    hall_flags == hall_flags_pin)
    else $error("lines driven with buffers off");
  AST_BUF_ON: assert property ( // see R12
    s_ff.buf_en |-> hall_flags == 4'h0 && !index_in)
    else $error("alternate pins live with buffers on");
  AST_QUAD_IDLE: assert property ( // see R15
    quad_mode && s_ff.st == ST_IDLE |=> s_ff.st == ST_IDLE)
    else $error("serial transfer in quadrature mode");
  AST_READ_LAT: assert property ( // see R10
    reg_rd && reg_addr == ADDR_SETUP && !reg_wr
    |=> reg_rdata == $past(s_ff.setup))
    else $error("read data not one cycle later");
endmodule

// ### tb/senc_encoder_model.sv
`timescale 1ns/1ps
// Encoder on the far side: SPI slave or two quadrature phases
module senc_encoder_model
(
  // Test controls
  input wire logic quad_mode,
  input wire logic quad_a,
  input wire logic quad_b,
  input wire logic [43:0] frame,
  input wire logic [5:0] frame_len,
  // Serial lines
  input wire senc_pkg::line_out_t line_out,
  output senc_pkg::line_in_t line_in
);
  import senc_pkg::*;
  // Bit shown on the data pair
  logic spi_bit = 1'b0;
  // Frame bits still to send
  logic [5:0] left = 6'h00;
  // High between select rise and fall
  logic in_frame = 1'b0;

  // New bit on each falling clock, MSB first
  always @(line_out.sel_o or line_out.clk_o)
  begin
    if (line_out.sel_o !== 1'b1)
    begin
      // Released line shows the inverse, so stale data never passes
      if (in_frame)
        spi_bit = ~spi_bit;
      in_frame = 1'b0;
    end
    else if (!in_frame)
    begin
      in_frame = 1'b1;
      left = frame_len;
    end
    else if (!line_out.clk_o && left != 6'h00)
    begin
      left = left - 6'h01;
      spi_bit = frame[left];
    end
  end

  // Phase A on the data pair, phase B on the clock pair
  assign line_in.data_i = quad_mode ? quad_a : spi_bit;
  assign line_in.clk_i = quad_mode ? quad_b : line_out.clk_o;
endmodule

// ### tb/senc_channel_tb.sv
`timescale 1ns/1ps
module senc_channel_tb;
  import senc_pkg::*;
  // Clock, reset and register port
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  // Motion clocks and pins
  logic phase_clk = 1'b0;
  logic servo_clk = 1'b0;
  line_in_t line_in;
  line_out_t line_out;
  logic [3:0] hall_flags_pin = 4'hA;
  logic index_pin = 1'b1;
  logic [3:0] hall_flags;
  logic index_in;
  logic alt_pins_valid;
  // Encoder model controls
  logic quad_mode = 1'b0;
  logic [1:0] qpos = 2'h0;
  logic [43:0] frame = 44'h0;
  logic [5:0] frame_len = 6'h10;
  // Scoreboard
  int err_count = 0;
  int num_checks = 0;
  logic [31:0] rd_val;
  logic [31:0] keep_a;

  // Free running 100 MHz clock
  always #5 ref_clk = ~ref_clk;

  senc_channel dut (.ref_clk(ref_clk), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .phase_clk(phase_clk),
    .servo_clk(servo_clk), .line_in(line_in), .line_out(line_out),
    .hall_flags_pin(hall_flags_pin), .index_pin(index_pin),
    .hall_flags(hall_flags), .index_in(index_in),
    .alt_pins_valid(alt_pins_valid));

  senc_encoder_model enc (.quad_mode(quad_mode), .quad_a(qpos[1] ^ qpos[0]),
    .quad_b(qpos[1]), .frame(frame), .frame_len(frame_len),
    .line_out(line_out), .line_in(line_in));

  task automatic check_word(input string name, input logic [31:0] exp,
                            input logic [31:0] got);
    num_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic check_bit(input string name, input logic exp,
                           input logic got);
    check_word(name, {31'h0, exp}, {31'h0, got});
  endtask

  // One-cycle write strobe
  task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic reg_read(input logic [3:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  // A clean pulse gives one rising and one falling edge
  task automatic pulse(input logic servo);
    @(posedge ref_clk);
    if (servo)
      servo_clk <= 1'b1;
    else
      phase_clk <= 1'b1;
    repeat (4) @(posedge ref_clk);
    servo_clk <= 1'b0;
    phase_clk <= 1'b0;
    repeat (4) @(posedge ref_clk);
  endtask

  // Poll the ready flag, bounded so a hang is reported
  task automatic wait_ready();
    int n;
    n = 0;
    rd_val = 32'h0;
    while (rd_val[READY_BIT] !== 1'b1 && n < 300)
    begin
      reg_read(ADDR_CTRL_WORD, rd_val);
      n++;
    end
    check_bit("ready after transfer", 1'b1, rd_val[READY_BIT]);
  endtask

  // Quadrature steps, A leading B counts up
  task automatic quad_steps(input int n, input logic up);
    repeat (n)
    begin
      qpos <= up ? qpos + 2'h1 : qpos - 2'h1;
      repeat (4) @(posedge ref_clk);
    end
  endtask

  function automatic logic [11:0] gray2bin(input logic [11:0] g);
    logic [11:0] b;
    b[11] = g[11];
    for (int i = 10; i >= 0; i--)
      b[i] = b[i + 1] ^ g[i];
    return b;
  endfunction

  task automatic summarize();
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // Watchdog well beyond the expected run length
  initial
  begin
    repeat (20000) @(posedge ref_clk);
    err_count++;
    summarize();
  end

  initial
  begin
    repeat (12) @(posedge ref_clk);
    rst_n <= 1'b1;
    reg_read(ADDR_CTRL_WORD, rd_val);
    check_word("control reset", CTRL_RESET, rd_val);
    reg_read(ADDR_SETUP, rd_val);
    check_word("setup reset", SETUP_RESET, rd_val);
    reg_read(4'hF, rd_val);
    check_word("unmapped read", 32'h0, rd_val);
    check_bit("alt pins valid", 1'b1, alt_pins_valid);
    check_word("hall flags", 32'hA, {28'h0, hall_flags});
    check_bit("index input", 1'b1, index_in);
    // Ready bit written high must read back low
    reg_write(ADDR_CTRL_WORD, 32'h5A5A_4F1C);
    reg_read(ADDR_CTRL_WORD, rd_val);
    check_word("control word", 32'h5A5A_4B1C, rd_val);
    // SPI at M=1: armed but buffers still off, so nothing starts
    reg_write(ADDR_SETUP, 32'h0100_0001);
    reg_write(ADDR_CTRL_WORD, 32'h0000_110C);
    pulse(1'b0);
    repeat (80) @(posedge ref_clk);
    check_bit("select oe off", 1'b0, line_out.sel_oe);
    reg_read(ADDR_CTRL_WORD, rd_val);
    check_bit("no start ready", 1'b0, rd_val[READY_BIT]);
    reg_write(ADDR_INPUT_CTRL, 32'h1);
    // Let the enable settle before looking at the pins
    #1;
    check_bit("alt pins off", 1'b0, alt_pins_valid);
    check_word("hall blocked", 32'h0, {28'h0, hall_flags});
    check_bit("clock oe", 1'b1, line_out.clk_oe);
    check_bit("select oe", 1'b1, line_out.sel_oe);
    // Two continuous samples, 12 position and 4 status bits
    frame <= {28'h0, 12'hABC, 4'h9};
    pulse(1'b0);
    wait_ready();
    reg_read(ADDR_RESULT_A, rd_val);
    check_word("position a", 32'hABC, rd_val);
    reg_read(ADDR_RESULT_B, rd_val);
    check_word("status b", 32'h0090_0000, rd_val);
    reg_read(ADDR_CTRL_WORD, rd_val);
    check_word("armed kept", 32'h0000_150C, rd_val);
    frame <= {28'h0, 12'h123, 4'h5};
    pulse(1'b0);
    reg_read(ADDR_CTRL_WORD, rd_val);
    check_bit("busy ready", 1'b0, rd_val[READY_BIT]);
    wait_ready();
    reg_read(ADDR_RESULT_A, rd_val);
    check_word("second sample", 32'h123, rd_val);
    // One-shot Gray sample on the servo falling edge, even parity
    reg_write(ADDR_SETUP, 32'h0103_0001);
    reg_write(ADDR_CTRL_WORD, 32'h0000_B90C);
    frame <= {28'h0, 12'hABC, 4'h0};
    pulse(1'b0);
    repeat (80) @(posedge ref_clk);
    reg_read(ADDR_RESULT_A, rd_val);
    check_word("phase ignored", 32'h123, rd_val);
    pulse(1'b1);
    wait_ready();
    reg_read(ADDR_RESULT_A, keep_a);
    check_word("gray decoded", {20'h0, gray2bin(12'hABC)}, keep_a);
    // Seven ones received: even parity must flag an error
    reg_read(ADDR_RESULT_B, rd_val);
    check_word("even parity error", 32'h0000_0001, rd_val);
    reg_read(ADDR_CTRL_WORD, rd_val);
    check_word("arm cleared", 32'h0000_AD0C, rd_val);
    frame <= {28'h0, 12'h555, 4'h0};
    pulse(1'b1);
    repeat (100) @(posedge ref_clk);
    reg_read(ADDR_RESULT_A, rd_val);
    check_word("disarmed hold", keep_a, rd_val);
    // Supplemental quadrature, control word left nonzero
    reg_write(ADDR_SETUP, 32'h0);
    quad_mode <= 1'b1;
    repeat (4) @(posedge ref_clk);
    check_bit("quad clock oe", 1'b0, line_out.clk_oe);
    quad_steps(8, 1'b1);
    pulse(1'b1);
    reg_read(ADDR_RESULT_A, rd_val);
    check_word("quad forward", 32'h8, {8'h0, rd_val[31:8]});
    quad_steps(3, 1'b0);
    pulse(1'b1);
    reg_read(ADDR_RESULT_A, rd_val);
    check_word("quad back", 32'h5, {8'h0, rd_val[31:8]});
    summarize();
  end
endmodule
